// ===== verilog/rtct_pkg.sv
// Package for the clock unit control and time-of-day block.
// Assumes a 32-bit register port with word indices as addresses.
`default_nettype none
package rtct_pkg;
    // Register word addresses
    localparam logic [3:0] RTCT_ADDR_CTRL = 4'h0;
    localparam logic [3:0] RTCT_ADDR_TIME = 4'h1;
    localparam logic [3:0] RTCT_ADDR_UNLK = 4'h2;
    // Control register field positions
    localparam int RTCT_CAL_LSB = 16;
    localparam int RTCT_CAL_W   = 10;
    localparam int RTCT_ON_BIT  = 15;
    localparam int RTCT_STOP_WHEN_IDLE_BIT = 13;
    localparam int RTCT_SEL_BIT = 7;
    localparam int RTCT_RUN_BIT = 6;
    localparam int RTCT_WREN_BIT = 3;
    localparam int RTCT_SYNC_BIT = 2;
    localparam int RTCT_HALF_BIT = 1;
    localparam int RTCT_OE_BIT  = 0;
    // Time register field positions
    localparam int RTCT_HOURS_TENS_LSB = 28;
    localparam int RTCT_HOURS_UNITS_LSB = 24;
    localparam int RTCT_MN10_LSB = 20;
    localparam int RTCT_MN01_LSB = 16;
    localparam int RTCT_SC10_LSB = 12;
    localparam int RTCT_SC01_LSB = 8;
    // Implemented bits of the time register
    localparam logic [31:0] RTCT_TIME_MASK = 32'h3F7F_7F00;
    // Reset values
    localparam logic [31:0] RTCT_CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] RTCT_TIME_RST = 32'h0000_0000;
    // Unlock key pair, written in order to the unlock word
    localparam logic [31:0] RTCT_KEY1 = 32'hAA99_6655;
    localparam logic [31:0] RTCT_KEY2 = 32'h5566_99AA;
    // Source clock ticks per second (32.768 kHz crystal)
    localparam int RTCT_TICKS_PER_SEC = 32768;
    // Seconds per minute, for the trim window
    localparam int RTCT_SEC_PER_MIN = 60;
endpackage
`default_nettype wire

// ===== verilog/rtct_bcd_time.sv
// BCD hours/minutes/seconds counter with a load port.
// Assumes one-cycle tick and load strobes in the system clock domain.
`timescale 1ns/1ps
`default_nettype none
module rtct_bcd_time
    import rtct_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Control
    input  wire logic        tick,
    input  wire logic        load,
    input  wire logic [31:0] load_val,
    // Time value, masked to implemented bits
    output logic      [31:0] time_q,
    output logic             min_wrap
);
    logic [3:0] s1;
    logic [2:0] s10;
    logic [3:0] m1;
    logic [2:0] m10;
    logic [3:0] h1;
    logic [1:0] h10;

    // Register assembly, unused bits zero
    // unused read zero
    assign time_q = {2'b00, h10, h1, 1'b0, m10, m1, 1'b0, s10, s1, 8'h00};
    assign min_wrap = tick && s10 == 3'd5 && s1 == 4'd9;

    // Counter with carries
    // BCD advance wrap
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {s1, s10, m1, m10, h1, h10} <= '0;
        end else if (load) begin
            h10 <= load_val[RTCT_HOURS_TENS_LSB +: 2];
            h1  <= load_val[RTCT_HOURS_UNITS_LSB +: 4];
            m10 <= load_val[RTCT_MN10_LSB +: 3];
            m1  <= load_val[RTCT_MN01_LSB +: 4];
            s10 <= load_val[RTCT_SC10_LSB +: 3];
            s1  <= load_val[RTCT_SC01_LSB +: 4];
        end else if (tick) begin
            if (s1 != 4'd9) begin
                s1 <= s1 + 4'd1;
            end else begin
                s1 <= 4'd0;
                if (s10 != 3'd5) begin
                    s10 <= s10 + 3'd1;
                end else begin
                    s10 <= 3'd0;
                    if (m1 != 4'd9) begin
                        m1 <= m1 + 4'd1;
                    end else begin
                        m1 <= 4'd0;
                        if (m10 != 3'd5) begin
                            m10 <= m10 + 3'd1;
                        end else begin
                            m10 <= 3'd0;
                            if (h10 == 2'd2 && h1 == 4'd3) begin
                                h10 <= 2'd0;
                                h1  <= 4'd0;
                            end else if (h1 == 4'd9) begin
                                h1  <= 4'd0;
                                h10 <= h10 + 2'd1;
                            end else begin
                                h1 <= h1 + 4'd1;
                            end
                        end
                    end
                end
            end
        end
    end
endmodule
`default_nettype wire

// ===== verilog/rtct_trim_div.sv
// Source tick divider with signed per-minute drift trim.
// Assumes src_tick is a one-cycle pulse per source clock period.
`timescale 1ns/1ps
`default_nettype none
module rtct_trim_div
    import rtct_pkg::*;
#(
    parameter int TICKS = RTCT_TICKS_PER_SEC
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Control
    input  wire logic        run,
    input  wire logic        clr,
    input  wire logic        src_tick,
    input  wire logic [9:0]  trim,
    input  wire logic        min_wrap,
    // Outputs
    output logic             sec_tick,
    output logic             half_q
);
    localparam int CW = $clog2(TICKS + 1);
    logic [CW-1:0] cnt_q;
    logic [9:0]    pend_q;    // Pulses still to add or remove
    logic          neg_q;
    logic          eff_tick;

    // Positive trim adds pulses, negative swallows them
    // add pulses
    assign eff_tick = run && (pend_q != 10'd0 ? (neg_q ? 1'b0 : 1'b1) : src_tick);
    assign sec_tick = eff_tick && cnt_q == CW'(TICKS - 1);

    // Trim pending budget, reloaded at each minute wrap only
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_q <= '0;
            neg_q  <= 1'b0;
        end else if (clr) begin
            // Time write starts a fresh minute with no leftover trim
            neg_q  <= 1'b0;
            pend_q <= '0;
        end else if (min_wrap) begin
            neg_q  <= trim[9];
            pend_q <= trim[9] ? 10'(-trim) : trim;
        end else if (run && pend_q != 10'd0 && neg_q == src_tick) begin
            // Added pulse waits out a real tick so none is lost
            pend_q <= pend_q - 10'd1;
        end
    end

    // Sub-second counter and half-second flag
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q  <= '0;
            half_q <= 1'b0;
        end else if (clr) begin
            cnt_q  <= '0;
            half_q <= 1'b0;
        end else if (eff_tick) begin
            if (sec_tick) begin
                cnt_q  <= '0;
                half_q <= 1'b0;
            end else begin
                cnt_q <= cnt_q + CW'(1);
                if (cnt_q == CW'(TICKS / 2 - 1)) begin
                    half_q <= 1'b1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ===== verilog/rtct_top.sv
// Clock unit control and time-of-day registers with BCD timekeeping.
// Assumes a synchronous register port and a source tick pulse input.
//
// What this block does
// - Positive trim adds N pulses per minute
// - Negative trim removes pulses per minute
// - Enable bit writable only with write gate
// - Stop-in-idle gates unit during idle
// - Select seconds or alarm; output enable gates
// - Status bit shows source clock running
// - Write gate settable only after unlock
// - Half-second flag read-only, cleared on seconds write
// - Control register reset only at power-on
// - Hours tens and units in BCD
// - Minutes tens and units in BCD
// - Seconds tens and units in BCD
// - Time writes need write gate set
// - Unused time bits read zero
//
// The address map and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module rtct_top
    import rtct_pkg::*;
#(
    parameter int TICKS = RTCT_TICKS_PER_SEC
) (
    // Clock and resets
    input  wire logic        ref_clk,
    input  wire logic        nrst,
    input  wire logic        sys_rst_n,
    // Register port
    input  wire logic [3:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    // Source clock and system state
    input  wire logic        src_tick,
    input  wire logic        src_running,
    input  wire logic        idle_mode,
    input  wire logic        alarm_pulse,
    // Output pin
    output logic             out_pin_o,
    output logic             out_pin_oe
);
    logic        rst_s1_q;
    logic        rst_n_q;
    logic        sysr_s1_q;
    logic        sysr_q;
    logic [9:0]  cal_q;
    logic        on_q;
    logic        stop_when_idle_q;
    logic        sel_q;
    logic        wren_q;
    logic        oe_q;
    logic        unlk_q;
    logic        key1_q;
    logic        run;
    logic        sec_tick;
    logic        half_q;
    logic        min_wrap;
    logic        sec_pulse_q;
    logic        sync_q;
    logic        time_load;
    logic        wr_ctrl;
    logic        wr_time;
    logic        wr_unlk;
    logic [31:0] time_q;
    logic [31:0] ctrl_view;

    // Power-on reset release through two flops
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rst_s1_q <= 1'b0;
            rst_n_q  <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_q  <= rst_s1_q;
        end
    end

    // Other reset sources, synchronised level
    always_ff @(posedge ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            sysr_s1_q <= 1'b0;
            sysr_q    <= 1'b0;
        end else begin
            sysr_s1_q <= !sys_rst_n;
            sysr_q    <= sysr_s1_q;
        end
    end

    // Write decode
    assign wr_ctrl = reg_wr && reg_addr == RTCT_ADDR_CTRL;
    assign wr_time = reg_wr && reg_addr == RTCT_ADDR_TIME;
    assign wr_unlk = reg_wr && reg_addr == RTCT_ADDR_UNLK;

    // Unlock sequence: two keys back to back, a control write or other unlock data cancels
    always_ff @(posedge ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            key1_q <= 1'b0;
            unlk_q <= 1'b0;
        end else if (sysr_q) begin
            key1_q <= 1'b0;
            unlk_q <= 1'b0;
        end else if (wr_unlk) begin
            key1_q <= reg_wdata == RTCT_KEY1;
            unlk_q <= key1_q && reg_wdata == RTCT_KEY2;
        end else if (wr_ctrl) begin
            key1_q <= 1'b0;
        end
    end

    // Control register, cleared only by power-on reset
    // power-on only
    always_ff @(posedge ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            cal_q  <= RTCT_CTRL_RST[RTCT_CAL_LSB +: RTCT_CAL_W];
            on_q   <= RTCT_CTRL_RST[RTCT_ON_BIT];
            stop_when_idle_q <= RTCT_CTRL_RST[RTCT_STOP_WHEN_IDLE_BIT];
            sel_q  <= RTCT_CTRL_RST[RTCT_SEL_BIT];
            wren_q <= RTCT_CTRL_RST[RTCT_WREN_BIT];
            oe_q   <= RTCT_CTRL_RST[RTCT_OE_BIT];
        end else if (wr_ctrl) begin
            cal_q  <= reg_wdata[RTCT_CAL_LSB +: RTCT_CAL_W];
            stop_when_idle_q <= reg_wdata[RTCT_STOP_WHEN_IDLE_BIT];
            sel_q  <= reg_wdata[RTCT_SEL_BIT];
            oe_q   <= reg_wdata[RTCT_OE_BIT];
            if (wren_q) begin
                on_q <= reg_wdata[RTCT_ON_BIT];
            end
            if (!reg_wdata[RTCT_WREN_BIT]) begin
                wren_q <= 1'b0;
            end else if (unlk_q) begin
                wren_q <= 1'b1;
            end
        end
    end

    // Unit runs when enabled and not stopped by idle
    // idle clock gating
    assign run = on_q && !(stop_when_idle_q && idle_mode);

    assign time_load = wr_time && wren_q;

    // Seconds divider with trim; time write clears half-second
    // clear on seconds write
    rtct_trim_div #(
        .TICKS    (TICKS)
    ) u_div (
        .clk      (ref_clk),
        .rst_n    (rst_n_q),
        .run      (run),
        .clr      (time_load),
        .src_tick (src_tick),
        .trim     (cal_q),
        .min_wrap (min_wrap),
        .sec_tick (sec_tick),
        .half_q   (half_q)
    );

    // BCD time counter
    rtct_bcd_time u_time (
        .clk      (ref_clk),
        .rst_n    (rst_n_q),
        .tick     (sec_tick),
        .load     (time_load),
        .load_val (reg_wdata),
        .time_q   (time_q),
        .min_wrap (min_wrap)
    );

    // Rollover warning: high in the last half second before a tick
    always_ff @(posedge ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            sync_q      <= 1'b0;
            sec_pulse_q <= 1'b0;
        end else begin
            sync_q      <= run && half_q;
            sec_pulse_q <= run && !half_q;
        end
    end

    // Output pin from flops
    // output source select
    always_ff @(posedge ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            out_pin_o  <= 1'b0;
            out_pin_oe <= 1'b0;
        end else begin
            out_pin_o  <= sel_q ? sec_pulse_q : alarm_pulse;
            out_pin_oe <= oe_q;
        end
    end

    // Control register read view
    // source running status
    always_comb begin
        ctrl_view = '0;
        ctrl_view[RTCT_CAL_LSB +: RTCT_CAL_W] = cal_q;
        ctrl_view[RTCT_ON_BIT]   = on_q;
        ctrl_view[RTCT_STOP_WHEN_IDLE_BIT] = stop_when_idle_q;
        ctrl_view[RTCT_SEL_BIT]  = sel_q;
        ctrl_view[RTCT_RUN_BIT]  = src_running;
        ctrl_view[RTCT_WREN_BIT] = wren_q;
        ctrl_view[RTCT_SYNC_BIT] = sync_q;
        ctrl_view[RTCT_HALF_BIT] = half_q;
        ctrl_view[RTCT_OE_BIT]   = oe_q;
    end

    // Read data one cycle after strobe, zero otherwise
    always_ff @(posedge ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            case (reg_addr)
                RTCT_ADDR_CTRL: reg_rdata <= ctrl_view;
                RTCT_ADDR_TIME: reg_rdata <= time_q & RTCT_TIME_MASK;
                default:        reg_rdata <= '0;
            endcase
        end else begin
            reg_rdata <= '0;
        end
    end
endmodule
`default_nettype wire

// ===== tb/rtct_top_props.sv
// Port assertions for the control and time-of-day block.
// Assumes a bind to rtct_top and one clock domain.
`timescale 1ns/1ps
`default_nettype none
module rtct_top_props
    import rtct_pkg::*;
#(
    parameter int TICKS = RTCT_TICKS_PER_SEC
) (
    // Clock and resets
    input wire logic        ref_clk,
    input wire logic        nrst,
    input wire logic        sys_rst_n,
    // Register port
    input wire logic [3:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    // Source, system and pin
    input wire logic        src_tick,
    input wire logic        src_running,
    input wire logic        idle_mode,
    input wire logic        alarm_pulse,
    input wire logic        out_pin_o,
    input wire logic        out_pin_oe
);
    logic       sel_q;
    logic       oe_q;
    logic       run_q;
    logic [2:0] stab_q;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    // Shadow of select and pin enable
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            sel_q <= 1'b0;
            oe_q  <= 1'b0;
        end else if (reg_wr && reg_addr == RTCT_ADDR_CTRL) begin
            sel_q <= reg_wdata[RTCT_SEL_BIT];
            oe_q  <= reg_wdata[RTCT_OE_BIT];
        end
    end
    // Cycles the source status has held
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            run_q  <= 1'b0;
            stab_q <= 3'h0;
        end else begin
            run_q  <= src_running;
            stab_q <= (src_running != run_q) ? 3'h0 : stab_q + 3'(stab_q != 3'h7);
        end
    end
    sequence s_rd_time;
        reg_rd && reg_addr == RTCT_ADDR_TIME;
    endsequence
    sequence s_rd_ctrl;
        reg_rd && reg_addr == RTCT_ADDR_CTRL && stab_q >= 3'h4;
    endsequence
    sequence s_wr_ctrl;
        reg_wr && reg_addr == RTCT_ADDR_CTRL;
    endsequence
    sequence s_ctrl_settle;
        s_wr_ctrl ##1 !(reg_wr && reg_addr == RTCT_ADDR_CTRL);
    endsequence
    property p_rd_idle;
        !$past(reg_rd) |-> reg_rdata == 32'h0000_0000;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
    property p_unused;
        s_rd_time |=> (reg_rdata & ~RTCT_TIME_MASK) == 32'h0000_0000;
    endproperty
    a_unused: assert property (p_unused) else $error("time spare bits set");
    property p_hours;
        s_rd_time |=> reg_rdata[29:28] <= 2'd2 && reg_rdata[27:24] <= 4'd9;
    endproperty
    a_hours: assert property (p_hours) else $error("hours not BCD");
    property p_mins;
        s_rd_time |=> reg_rdata[22:20] <= 3'd5 && reg_rdata[19:16] <= 4'd9;
    endproperty
    a_mins: assert property (p_mins) else $error("minutes not BCD");
    property p_secs;
        s_rd_time |=> reg_rdata[14:12] <= 3'd5 && reg_rdata[11:8] <= 4'd9;
    endproperty
    a_secs: assert property (p_secs) else $error("seconds not BCD");
    property p_run;
        s_rd_ctrl |=> reg_rdata[RTCT_RUN_BIT] == run_q;
    endproperty
    a_run: assert property (p_run) else $error("run status wrong");
    property p_oe;
        s_ctrl_settle |=> out_pin_oe == $past(reg_wdata[RTCT_OE_BIT], 2);
    endproperty
    a_oe: assert property (p_oe) else $error("pin enable wrong");
    property p_alarm;
        !$past(sel_q) && $past(oe_q) |-> out_pin_o == $past(alarm_pulse);
    endproperty
    a_alarm: assert property (p_alarm) else $error("pin not alarm");
endmodule
bind rtct_top rtct_top_props #(.TICKS(TICKS)) u_props (.ref_clk, .nrst, .sys_rst_n,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .src_tick, .src_running,
    .idle_mode, .alarm_pulse, .out_pin_o, .out_pin_oe);
`default_nettype wire

// ===== tb/rtct_top_tb.sv
// Self-checking bench for the control and time-of-day block.
// Assumes TICKS of 8 and word-indexed register addresses.
`timescale 1ns/1ps
`default_nettype none
module rtct_top_tb
    import rtct_pkg::*;
;
    logic        ref_clk = 1'b0;
    logic        nrst = 1'b0;
    logic        sys_rst_n = 1'b1;
    logic [3:0]  reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        src_tick = 1'b0;
    logic        src_running = 1'b1;
    logic        idle_mode = 1'b0;
    logic        alarm_pulse = 1'b0;
    logic        rd_q = 1'b0;
    logic        out_pin_o;
    logic        out_pin_oe;
    logic [31:0] reg_rdata;
    logic [31:0] exp_q[$];
    logic [31:0] msk_q[$];
    logic [31:0] seed = 32'h0000_f836;
    logic [31:0] ew, t, me, mm, ra;
    logic [7:0]  h, m, s;
    int          num_errors = 0;
    int          comparisons = 0;
    int          cyc = 0;
    int          k;
    always #12.5 ref_clk = ~ref_clk;
    rtct_top #(.TICKS(8)) dut (.ref_clk, .nrst, .sys_rst_n, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .src_tick, .src_running, .idle_mode,
        .alarm_pulse, .out_pin_o, .out_pin_oe);
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [7:0] bcd(input logic [31:0] v);
        return 8'(((v / 10) << 4) | (v % 10));
    endfunction
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] mk);
        exp_q.push_back(e);
        msk_q.push_back(mk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic tk(input int n);
        repeat (n) begin
            src_tick <= 1'b1;
            @(posedge ref_clk);
            src_tick <= 1'b0;
            @(posedge ref_clk);
        end
        repeat (4) @(posedge ref_clk);
    endtask
    task automatic give_verdict();
        $display("comparisons %0d num_errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Read result checker and alarm noise
    always @(posedge ref_clk) begin
        rd_q <= reg_rd;
        ra = rnd();
        alarm_pulse <= ra[3];
        if (rd_q) begin
            me = exp_q.pop_front();
            mm = msk_q.pop_front();
            comparisons++;
            if ((reg_rdata & mm) !== (me & mm)) begin
                num_errors++;
                $display("CHECK FAILED reg_rdata exp %h got %h", me & mm, reg_rdata & mm);
            end
        end
    end
    // Hang guard
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            give_verdict();
        end
    end
    initial begin
        repeat (6) @(posedge ref_clk);
        nrst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        rd(RTCT_ADDR_CTRL, 32'h0000_0040, '1);
        rd(RTCT_ADDR_TIME, 32'h0000_0000, '1);
        wr(RTCT_ADDR_TIME, 32'h1234_5600);
        wr(RTCT_ADDR_CTRL, 32'h0000_8008);
        rd(RTCT_ADDR_TIME, 32'h0000_0000, '1);
        rd(RTCT_ADDR_CTRL, 32'h0000_0040, '1);
        wr(RTCT_ADDR_UNLK, RTCT_KEY1);
        wr(RTCT_ADDR_UNLK, RTCT_KEY2);
        wr(RTCT_ADDR_CTRL, 32'h0000_0008);
        wr(RTCT_ADDR_CTRL, 32'h0000_8009);
        rd(RTCT_ADDR_CTRL, 32'h0000_8049, '1);
        // Random time loads over stale half and sync flags
        for (k = 0; k < 6; k++) begin
            tk(5);
            rd(RTCT_ADDR_CTRL, 32'h0000_804F, '1);
            t  = rnd();
            h  = bcd(t[7:0] % 24);
            m  = bcd(t[15:8] % 60);
            s  = bcd(t[23:16] % 60);
            ew = {2'b00, h[5:0], 1'b0, m[6:0], 1'b0, s[6:0], 8'h00};
            wr(RTCT_ADDR_TIME, ew | (t & ~RTCT_TIME_MASK));
            rd(RTCT_ADDR_TIME, ew, '1);
            rd(RTCT_ADDR_CTRL, 32'h0000_8049, '1);
        end
        wr(RTCT_ADDR_TIME, 32'h2359_5800);
        tk(16);
        rd(RTCT_ADDR_TIME, 32'h0000_0000, '1);
        wr(RTCT_ADDR_CTRL, 32'h0000_A008);
        idle_mode <= 1'b1;
        tk(8);
        rd(RTCT_ADDR_TIME, 32'h0000_0000, '1);
        idle_mode <= 1'b0;
        tk(8);
        rd(RTCT_ADDR_TIME, 32'h0000_0100, '1);
        // Trim +3 then -2 on the second after a minute wrap
        for (k = 0; k < 2; k++) begin
            wr(RTCT_ADDR_CTRL, {6'h00, (k == 0) ? 10'h003 : 10'h3FE, 16'h8009});
            wr(RTCT_ADDR_TIME, 32'h0000_5900);
            tk(8);
            tk((k == 0) ? 4 : 9);
            rd(RTCT_ADDR_TIME, 32'h0001_0000, '1);
            tk(1);
            rd(RTCT_ADDR_TIME, 32'h0001_0100, '1);
        end
        sys_rst_n <= 1'b0;
        repeat (3) @(posedge ref_clk);
        sys_rst_n <= 1'b1;
        rd(RTCT_ADDR_CTRL, 32'h03FE_8049, 32'hFFFF_FFF9);
        rd(RTCT_ADDR_TIME, 32'h0001_0100, '1);
        // Disable, then the task's idle cycle before the next access
        wr(RTCT_ADDR_CTRL, 32'h0000_0000);
        wr(RTCT_ADDR_CTRL, 32'h0000_8008);
        rd(RTCT_ADDR_CTRL, 32'h0000_0040, '1);
        tk(8);
        rd(RTCT_ADDR_TIME, 32'h0001_0100, '1);
        wr(4'hF, rnd());
        rd(4'hF, 32'h0000_0000, '1);
        // Seconds source on the pin while stopped stays low under alarm noise
        wr(RTCT_ADDR_CTRL, 32'h0000_0081);
        repeat (2) @(posedge ref_clk);
        repeat (8) begin
            @(negedge ref_clk);
            comparisons++;
            if (out_pin_o !== 1'b0 || out_pin_oe !== 1'b1) begin
                num_errors++;
                $display("CHECK FAILED out_pin_oe,out_pin_o exp 10 got %b%b", out_pin_oe, out_pin_o);
            end
        end
        @(posedge ref_clk);
        src_running <= 1'b0;
        repeat (6) @(posedge ref_clk);
        rd(RTCT_ADDR_CTRL, 32'h0000_0000, 32'h0000_0040);
        repeat (2) @(posedge ref_clk);
        give_verdict();
    end
endmodule
`default_nettype wire
